// >>> src/dacr_cfg.svh
// Timing and format constants for the dual converter readout block
`ifndef DACR_CFG_SVH
`define DACR_CFG_SVH

`define DACR_DATA_W       14
`define DACR_FIFO_DEPTH   4
`define DACR_CLK_MHZ      50
`define DACR_CONV_NS      5200
`define DACR_CYCLE_NS     5700
// Longest time rounds down: 260 cycles
`define DACR_CONV_CYC     ((`DACR_CONV_NS * `DACR_CLK_MHZ) / 1000)
// Least time rounds up: 285 cycles
`define DACR_CYCLE_CYC    ((`DACR_CYCLE_NS * `DACR_CLK_MHZ + 999) / 1000)
// Counter end value leaves room for pin sync and the two result writes
`define DACR_CONV_LAST    (`DACR_CONV_CYC - 6)
// Busy rise to busy fall, less the three cycles of pin sync and detection
`define DACR_BUSY_MAX     (`DACR_CONV_CYC - 3)
`define DACR_SIGN_BIT     13
`define DACR_CNT_W        9

`endif

// >>> src/dacr_pkg.sv
// Types shared by the dual converter readout block
package dacr_pkg;
    `include "dacr_cfg.svh"

    typedef logic [`DACR_DATA_W-1:0] dacr_word_t;

    typedef struct packed {
        logic conv_n;
        logic sel;
        logic cs_n;
        logic rd_n;
    } dacr_pins_s;

    typedef struct packed {
        dacr_word_t first;
        dacr_word_t second;
    } dacr_pair_s;

    typedef enum logic [1:0] {
        DACR_IDLE,
        DACR_CONV,
        DACR_PUSH1,
        DACR_PUSH2
    } dacr_state_e;
endpackage : dacr_pkg

// >>> src/dacr_fifo.sv
// Small result FIFO with valid/ready on both sides
`timescale 1ns/1ps
module dacr_fifo #(
    parameter int W = 14,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem_q [D];
    logic [AW:0]  wr_q;
    logic [AW:0]  rd_q;
    wire          full  = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
    wire          empty = (wr_q == rd_q);
    wire          push  = in_valid && !full;
    wire          pop   = out_ready && !empty;

    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rd_q[AW-1:0]];

    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
        end else begin
            wr_q <= wr_q + (AW+1)'(push);
            rd_q <= rd_q + (AW+1)'(pop);
        end
    end
endmodule : dacr_fifo

// >>> src/dacr_top.sv
// Conversion control and parallel readout of a dual simultaneous-sampling converter
// How it works
// - A falling edge on conversion_start_n starts a conversion of both inputs of the selected pair.
// - On the third clock edge after that edge both track-and-hold stages go into hold together.
// - Results sit in the output store no later than 5.2 us after the start edge while the result FIFO has room for both words.
// - BUSY falling marks end of conversion, after which both results of the pair can be read.
// - With pair_select low, the first read returns pair A first input and the second read pair A second input.
// - With pair_select high, the next two reads return pair B first input then pair B second input.
// - A full sample cycle is at least 5.7 us and starts arriving faster are not honoured.
// - Bipolar variants give 14-bit two's complement codes of span over 16,384.
// - The unipolar variant gives 14-bit straight binary codes with zero at ground.
// - Chip select falling together with read also works; a read strobe that falls while chip select is high reads no word.
// - BUSY goes high on the third clock edge after the start edge and stays high until both results are in the result FIFO.
// - At end of conversion both track-and-hold stages return to tracking.
`timescale 1ns/1ps
`include "dacr_cfg.svh"
module dacr_top
    import dacr_pkg::*;
#(
    parameter bit BIPOLAR = 1'b1
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       conversion_start_n,
    input  wire logic       pair_select,
    input  wire logic       cs_n,
    input  wire logic       rd_n,
    input  wire dacr_word_t pair_a_input_first,
    input  wire dacr_word_t pair_a_input_second,
    input  wire dacr_word_t pair_b_input_first,
    input  wire dacr_word_t pair_b_input_second,
    output logic            busy,
    output logic            track_hold_hold,
    output dacr_word_t      data_out,
    output logic            data_oe
);
    localparam int BUSY_MAX = `DACR_BUSY_MAX;

    // Sample inputs arrive as offset binary; bipolar flips the sign bit
    function automatic dacr_word_t fmt_code(input dacr_word_t raw);
        fmt_code = raw;
        fmt_code[`DACR_SIGN_BIT] = raw[`DACR_SIGN_BIT] ^ BIPOLAR;
    endfunction : fmt_code

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    dacr_pins_s pins_raw;
    dacr_pins_s s1_q;
    dacr_pins_s s2_q;
    dacr_pins_s s3_q;

    assign pins_raw = '{conv_n: conversion_start_n, sel: pair_select, cs_n: cs_n, rd_n: rd_n};

    always_ff @(posedge clk) begin
        if (rst) begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end else begin
            s1_q <= pins_raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    wire conv_fall = s3_q.conv_n && !s2_q.conv_n;
    wire rd_fall   = s3_q.rd_n && !s2_q.rd_n && !s2_q.cs_n;
    wire bus_sel   = !s2_q.cs_n && !s2_q.rd_n;

    ////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    dacr_state_e             state_q;
    dacr_state_e             state_d;
    logic [`DACR_CNT_W-1:0]  cnt_q;
    logic [`DACR_CNT_W-1:0]  gap_q;
    dacr_pair_s              held_q;
    logic                    busy_q;
    logic                    hold_q;
    logic                    fifo_in_ready;
    dacr_word_t              fifo_in_data;

    wire        cycle_ok  = (gap_q == `DACR_CNT_W'(`DACR_CYCLE_CYC));
    wire        start_ok  = conv_fall && (state_q == DACR_IDLE) && cycle_ok;
    wire        conv_done = (cnt_q == `DACR_CNT_W'(`DACR_CONV_LAST));
    wire        fifo_in_valid = (state_q == DACR_PUSH1) || (state_q == DACR_PUSH2);
    wire        push_done = (state_q == DACR_PUSH2) && fifo_in_ready;
    dacr_pair_s pair_now;

    assign pair_now = s2_q.sel ? dacr_pair_s'{first: pair_b_input_first, second: pair_b_input_second}
                               : dacr_pair_s'{first: pair_a_input_first, second: pair_a_input_second};
    assign fifo_in_data = fmt_code((state_q == DACR_PUSH1) ? held_q.first : held_q.second);

    always_comb begin
        state_d = state_q;
        case (state_q)
            DACR_IDLE: begin
                if (start_ok) state_d = DACR_CONV;
            end
            DACR_CONV: begin
                if (conv_done) state_d = DACR_PUSH1;
            end
            DACR_PUSH1: begin
                if (fifo_in_ready) state_d = DACR_PUSH2;
            end
            DACR_PUSH2: begin
                if (fifo_in_ready) state_d = DACR_IDLE;
            end
            default: state_d = DACR_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= DACR_IDLE;
            cnt_q   <= '0;
            gap_q   <= `DACR_CNT_W'(`DACR_CYCLE_CYC);
        end else begin
            state_q <= state_d;
            cnt_q   <= (state_q == DACR_CONV) ? cnt_q + 1'b1 : '0;
            // Counts from one so a start exactly one full cycle later is honoured
            if (start_ok) gap_q <= `DACR_CNT_W'(1);
            else if (!cycle_ok) gap_q <= gap_q + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            held_q <= '0;
            busy_q <= 1'b0;
            hold_q <= 1'b0;
        end else if (start_ok) begin
            held_q <= pair_now;
            busy_q <= 1'b1;
            hold_q <= 1'b1;
        end else if (push_done) begin
            busy_q <= 1'b0;
            hold_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Result FIFO and parallel read port
    logic       fifo_out_valid;
    dacr_word_t fifo_out_data;
    dacr_word_t data_q;
    logic       oe_q;
    wire        pop = rd_fall && fifo_out_valid;

    dacr_fifo #(
        .W (`DACR_DATA_W),
        .D (`DACR_FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rst       (rst),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (fifo_in_data),
        .out_valid (fifo_out_valid),
        .out_ready (pop),
        .out_data  (fifo_out_data)
    );

    // A strobe with nothing queued repeats the last word
    always_ff @(posedge clk) begin
        if (rst) begin
            data_q <= '0;
            oe_q   <= 1'b0;
        end else begin
            if (pop) data_q <= fifo_out_data;
            oe_q <= bus_sel;
        end
    end

    assign busy            = busy_q;
    assign track_hold_hold = hold_q;
    assign data_out        = data_q;
    assign data_oe         = oe_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    busy_rise_a: assert property (@(posedge clk) disable iff (rst)
        start_ok |=> busy_q && hold_q)
        else $error("busy or hold not raised after start");

    hold_tracks_busy_a: assert property (@(posedge clk) disable iff (rst)
        hold_q == busy_q)
        else $error("hold and busy disagree");

    conv_time_a: assert property (@(posedge clk) disable iff (rst)
        $rose(busy_q) |-> ##[1:BUSY_MAX] (!busy_q || !fifo_in_ready))
        else $error("conversion too long");

    pair_capture_a: assert property (@(posedge clk) disable iff (rst)
        start_ok |=> held_q == $past(pair_now))
        else $error("wrong pair captured");

    push_order_a: assert property (@(posedge clk) disable iff (rst)
        (state_q == DACR_PUSH1) && fifo_in_ready |-> fifo_in_data == fmt_code(held_q.first)
            ##1 (fifo_in_data == fmt_code(held_q.second)))
        else $error("results queued out of order");

    code_format_a: assert property (@(posedge clk) disable iff (rst)
        fifo_in_valid |-> fifo_in_data[`DACR_SIGN_BIT] ==
            ((state_q == DACR_PUSH1 ? held_q.first[`DACR_SIGN_BIT] : held_q.second[`DACR_SIGN_BIT]) ^ BIPOLAR))
        else $error("output code format wrong");

    start_spacing_a: assert property (@(posedge clk) disable iff (rst)
        start_ok |=> !start_ok [*8])
        else $error("starts too close");

    oe_gating_a: assert property (@(posedge clk) disable iff (rst)
        data_oe == $past(bus_sel))
        else $error("bus driven without chip select and read");

    start_gate_a: assert property (@(posedge clk) disable iff (rst)
        conv_fall && (state_q != DACR_IDLE) |=> $stable(held_q))
        else $error("start accepted during conversion");

    track_release_a: assert property (@(posedge clk) disable iff (rst)
        $fell(busy_q) |-> !hold_q && $past(state_q) == DACR_PUSH2)
        else $error("hold not released at end of conversion");

    read_data_a: assert property (@(posedge clk) disable iff (rst)
        pop |=> data_q == $past(fifo_out_data))
        else $error("read strobe returned wrong word");
endmodule : dacr_top

// >>> verification/dacr_host.sv
// Host bus model for the dual converter readout block
`timescale 1ns/1ps
module dacr_host
    import dacr_pkg::*;
(
    input  wire logic       clk,
    input  wire dacr_word_t data_out,
    input  wire logic       data_oe,
    output logic            conversion_start_n,
    output logic            pair_select,
    output logic            cs_n,
    output logic            rd_n
);
    int cyc = 0;
    int stamp = -1000;
    initial begin
        conversion_start_n = 1'b1;
        pair_select = 1'b0;
        cs_n = 1'b1;
        rd_n = 1'b1;
    end
    always @(posedge clk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////
    task automatic start(input logic sel);
        @(posedge clk) #1;
        pair_select = sel;
        repeat (25) @(posedge clk);
        while (cyc - stamp < 290) @(posedge clk);
        #1 conversion_start_n = 1'b0;
        stamp = cyc;
        repeat (5) @(posedge clk);
        #1 conversion_start_n = 1'b1;
    endtask : start
    // One strobe; the word is taken while the strobe is still low
    task automatic strobe(output dacr_word_t w, output logic oe);
        @(posedge clk) #1 rd_n = 1'b0;
        repeat (6) @(posedge clk);
        w = data_out;
        oe = data_oe;
        #1 rd_n = 1'b1;
        repeat (5) @(posedge clk);
    endtask : strobe
    task automatic read_pair(output dacr_word_t w1, output dacr_word_t w2, output logic oe);
        logic oe2;
        @(posedge clk) #1 cs_n = 1'b0;
        strobe(w1, oe);
        strobe(w2, oe2);
        oe = oe & oe2;
        #1 cs_n = 1'b1;
        repeat (5) @(posedge clk);
    endtask : read_pair
    // Start pulse that ignores the spacing, for refusal tests
    task automatic rush_start;
        @(posedge clk) #1 conversion_start_n = 1'b0;
        repeat (5) @(posedge clk);
        #1 conversion_start_n = 1'b1;
    endtask : rush_start
endmodule : dacr_host

// >>> verification/tb_dacr_top.sv
// Self-checking testbench for the dual converter readout block
`timescale 1ns/1ps
`include "dacr_cfg.svh"
module tb_dacr_top;
    import dacr_pkg::*;
    localparam dacr_word_t A1 = 14'h0123;
    localparam dacr_word_t A2 = 14'h2ABC;
    localparam dacr_word_t B1 = 14'h3FFF;
    localparam dacr_word_t B2 = 14'h0000;
    // Offset binary to two's complement flips the sign bit
    localparam dacr_word_t FLIP = 14'h2000;
    logic       clk;
    logic       rst;
    logic       conv_n;
    logic       sel;
    logic       cs_n;
    logic       rd_n;
    logic       busy;
    logic       thh;
    logic       data_oe;
    logic       oe;
    dacr_word_t data_out;
    dacr_word_t data_out_u;
    dacr_word_t w1;
    dacr_word_t w2;
    int         bad_count = 0;
    int         num_checks = 0;
    int         n;
    dacr_top i_dacr_top (.clk(clk), .rst(rst), .conversion_start_n(conv_n), .pair_select(sel), .cs_n(cs_n),
        .rd_n(rd_n), .pair_a_input_first(A1), .pair_a_input_second(A2), .pair_b_input_first(B1),
        .pair_b_input_second(B2), .busy(busy), .track_hold_hold(thh), .data_out(data_out), .data_oe(data_oe));
    dacr_host i_dacr_host (.clk(clk), .data_out(data_out), .data_oe(data_oe), .conversion_start_n(conv_n),
        .pair_select(sel), .cs_n(cs_n), .rd_n(rd_n));
    // Unipolar variant on the same pins; only its data is watched
    dacr_top #(.BIPOLAR(1'b0)) i_dacr_top_uni (.clk(clk), .rst(rst), .conversion_start_n(conv_n),
        .pair_select(sel), .cs_n(cs_n), .rd_n(rd_n), .pair_a_input_first(A1), .pair_a_input_second(A2),
        .pair_b_input_first(B1), .pair_b_input_second(B2), .busy(), .track_hold_hold(), .data_out(data_out_u),
        .data_oe());
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Counts cycles until busy falls, giving up at lim
    task automatic wait_idle(input int lim, output int cnt);
        cnt = 0;
        while (busy !== 1'b0 && cnt < lim) begin
            @(posedge clk) #1;
            cnt++;
        end
        if (busy !== 1'b0) begin
            check(busy, 0);
            end_of_test();
        end
    endtask : wait_idle
    ////////////////////////////////////////////////////////////////
    task automatic conv_pair(input logic s, input dacr_word_t e1, input dacr_word_t e2);
        i_dacr_host.start(s);
        check(busy, 1);
        check(thh, 1);
        wait_idle(300, n);
        check(n + 5 <= `DACR_CONV_CYC, 1);
        check(thh, 0);
        i_dacr_host.read_pair(w1, w2, oe);
        check(w1, e1 ^ FLIP);
        check(w2, e2 ^ FLIP);
        check(data_out_u, e2);
        check(oe, 1);
        check(data_oe, 0);
    endtask : conv_pair
    // A start too soon after the last accepted one is ignored
    task automatic refused_start;
        i_dacr_host.start(1'b0);
        wait_idle(300, n);
        i_dacr_host.rush_start();
        repeat (5) @(posedge clk);
        #1;
        check(busy, 0);
        i_dacr_host.read_pair(w1, w2, oe);
        check({w1, w2}, {A1 ^ FLIP, A2 ^ FLIP});
    endtask : refused_start
    // Three conversions unread: the fifth and sixth words find the buffer full
    task automatic fifo_stall;
        i_dacr_host.start(1'b0);
        i_dacr_host.start(1'b1);
        i_dacr_host.start(1'b0);
        repeat (350) @(posedge clk);
        #1;
        check(busy, 1);
        i_dacr_host.read_pair(w1, w2, oe);
        check({w1, w2}, {A1 ^ FLIP, A2 ^ FLIP});
        wait_idle(40, n);
        check(busy, 0);
        i_dacr_host.read_pair(w1, w2, oe);
        check({w1, w2}, {B1 ^ FLIP, B2 ^ FLIP});
        i_dacr_host.read_pair(w1, w2, oe);
        check({w1, w2}, {A1 ^ FLIP, A2 ^ FLIP});
        i_dacr_host.read_pair(w1, w2, oe);
        check({w1, w2}, {A2 ^ FLIP, A2 ^ FLIP});
    endtask : fifo_stall
    ////////////////////////////////////////////////////////////////
    initial begin
        rst = 1'b1;
        repeat (6) @(posedge clk);
        #1 rst = 1'b0;
        check(busy, 0);
        check(thh, 0);
        check(data_oe, 0);
        check(data_out, 0);
        conv_pair(1'b0, A1, A2);
        conv_pair(1'b1, B1, B2);
        refused_start();
        fifo_stall();
        end_of_test();
    end
endmodule : tb_dacr_top
